// file: rtl/rr_exec_regs.svh
// Register map, field positions and timing counts of the execute unit.
//Contract
//RULE_01: Bits 15..12 all zero mark a register-reference instruction.
//RULE_02: Code 0 halts when the halt switch is on; restart resumes at P+1.
//RULE_03: Code 2 reads one word from the device chosen by aux into acc.
//RULE_04: Code 3 sends acc to the device chosen by aux.
//RULE_05: Reply gives P+1, device reject P+1+delta, internal reject P+delta.
//RULE_06: Code 9 adds sign-extended delta to acc, overflow as for add.
//RULE_07: Enter-acc loads acc with sign-extended delta.
//RULE_08: Enter-aux loads aux with sign-extended delta.
//RULE_09: No-operation only advances P, like halt with switch off.
//RULE_10: Code D adds sign-extended delta to aux, overflow as for add.
//RULE_11: Codes 4,5,6,7,E need protect off or protected word, else halt.
//RULE_12: Code 4 activates interrupts after one further instruction completes.
//RULE_13: Interrupt recognised only while system active and mask bit set.
//RULE_14: Code 5 deactivates interrupts until after the next enable.
//RULE_15: Codes 6 and 7 set or clear protect bit of word at aux.
//RULE_16: Code E reads the return word chosen by delta and jumps there.
//RULE_17: In 32K mode exit copies return bit 15 to overflow; 65K leaves it.
//RULE_18: Unprotected inter-register write to mask halts and flags a fault.
//RULE_19: First operand is all ones, or acc when bit 5 set.
//RULE_20: Bits 4,3 pick all ones, mask, aux, or aux OR mask.
//RULE_21: Select bits pick xor, and, nand, or one's complement sum.
//RULE_22: Bits 2,1,0 write acc, aux, mask; none updates only overflow.
//RULE_23: All adder arithmetic is one's complement.
//RULE_24: Overflow stays set until a skip on overflow clears it.
//RULE_25: Function code is bits 11..8, signed delta bits 7..0.
`ifndef RR_EXEC_REGS_SVH
`define RR_EXEC_REGS_SVH

// APB byte offsets
`define RR_CTRL_OFS   8'h00
`define RR_STAT_OFS   8'h04
`define RR_ACC_OFS    8'h08
`define RR_AUX_OFS    8'h0c
`define RR_MASK_OFS   8'h10

// Control fields
`define RR_CTRL_HALT  0
`define RR_CTRL_PROT  1
`define RR_CTRL_M32K  2
`define RR_CTRL_RUN   3
`define RR_CTRL_RST   3'h0

// Status fields
`define RR_ST_HALT    0
`define RR_ST_OVF     1
`define RR_ST_INTA    2
`define RR_ST_FAULT   3
`define RR_ST_PEND    4
`define RR_ST_BUSY    5

// Function codes
`define RR_FC_HALT    4'h0
`define RR_FC_IN      4'h2
`define RR_FC_OUT     4'h3
`define RR_FC_INT_ON  4'h4
`define RR_FC_INT_OFF 4'h5
`define RR_FC_PSET    4'h6
`define RR_FC_PCLR    4'h7
`define RR_FC_IREG    4'h8
`define RR_FC_BUMPA   4'h9
`define RR_FC_LDA     4'ha
`define RR_FC_NOP     4'hb
`define RR_FC_LDQ     4'hc
`define RR_FC_BUMPQ   4'hd
`define RR_FC_EXIT    4'he

// Internal reject time and its cycle count at 40 MHz
`define RR_CLK_NS     25
`define RR_IOREJ_NS   10000
`define RR_IOREJ_CYC  (`RR_IOREJ_NS / `RR_CLK_NS)

`endif

// file: rtl/rr_exec_pkg.sv
// Types shared by the register-reference execute unit.
package rr_exec_pkg;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_EXEC = 3'h1,
		S_IO   = 3'h3,
		S_MEM  = 3'h2,
		S_HALT = 3'h6
	} exec_state_t;

	typedef struct packed {
		logic        dir_out;
		logic [15:0] addr;
		logic [15:0] wdata;
	} io_req_t;

endpackage

// file: rtl/register_reference_exec.sv
// Register-reference and inter-register execute unit with APB access.
`timescale 1ns/10ps
`default_nettype none
`include "rr_exec_regs.svh"

module register_reference_exec
	import rr_exec_pkg::*;
#(
	parameter int IO_WAIT_MAX = `RR_IOREJ_CYC
) (
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Instruction issue
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_prot,
	input  wire logic [15:0] instr_pc,
	input  wire logic        ovf_clear,
	output logic             busy,
	output logic             done,
	output logic      [15:0] next_pc,
	// Device transfer
	output io_req_t          io_out,
	output logic             io_strobe,
	input  wire logic        io_reply,
	input  wire logic        io_reject,
	input  wire logic [15:0] io_rdata,
	// Storage side
	output logic             mem_rd,
	output logic             prot_wr,
	output logic             prot_val,
	output logic      [15:0] mem_addr,
	input  wire logic        mem_valid,
	input  wire logic [15:0] mem_rdata,
	// Interrupt and status
	input  wire logic [15:0] irq_req,
	output logic             int_active,
	output logic             int_pending,
	output logic             fault_pulse,
	output logic             halted,
	output logic             overflow
);

	initial begin
		if (IO_WAIT_MAX < 2 || IO_WAIT_MAX > 65535) begin
			$error("IO_WAIT_MAX out of range");
		end
	end

	exec_state_t state_q;
	logic [15:0] ir_q, pc_q, acc_q, aux_q, mask_q;
	logic        irp_q, ovf_q, arm_q, inta_q, pend_q;
	logic        fault_q, fpulse_q, done_q, strobe_q;
	logic        memrd_q, protwr_q, protv_q, busy_q, halt_q;
	logic [15:0] npc_q, maddr_q;
	logic [2:0]  ctrl_q;
	logic [15:0] tmo_q;
	io_req_t     io_q;
	logic [33:0] sy1_q, sy2_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;

	// Device answer and interrupt pins pass two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else if (clk_en) begin
			sy1_q <= {io_reply, io_reject, io_rdata, irq_req};
			sy2_q <= sy1_q;
		end
	end

	logic        rep_s, rej_s;
	logic [15:0] rdat_s, irq_s;
	assign rep_s  = sy2_q[33];
	assign rej_s  = sy2_q[32];
	assign rdat_s = sy2_q[31:16];
	assign irq_s  = sy2_q[15:0];

	// One's complement add with end-around carry [RULE_23]
	function automatic logic [16:0] oc_add(
		input logic [15:0] a,
		input logic [15:0] b
	);
		logic [16:0] s;
		logic [15:0] r;
		s = {1'b0, a} + {1'b0, b};
		r = s[15:0] + {15'h0000, s[16]};
		return {(a[15] == b[15]) && (r[15] != a[15]), r};
	endfunction

	// Field decode [RULE_25]
	logic [3:0]  fc;
	logic [15:0] dsx;
	logic        ex, grp, priv, legal, mviol, stop, go;
	assign fc    = ir_q[11:8];
	assign dsx   = {{8{ir_q[7]}}, ir_q[7:0]};
	assign ex    = (state_q == S_EXEC);
	assign grp   = (ir_q[15:12] == 4'h0); // [RULE_01]
	assign priv  = fc inside {`RR_FC_INT_ON, `RR_FC_INT_OFF, `RR_FC_PSET,
		`RR_FC_PCLR, `RR_FC_EXIT};
	assign legal = !ctrl_q[`RR_CTRL_PROT] || irp_q; // [RULE_11]
	// Writing mask unprotected is a violation [RULE_18]
	assign mviol = (fc == `RR_FC_IREG) && ir_q[0] && !irp_q &&
		ctrl_q[`RR_CTRL_PROT];
	assign stop  = ex && grp && ((fc == `RR_FC_HALT &&
		ctrl_q[`RR_CTRL_HALT]) || (priv && !legal) || mviol); // [RULE_02]
	assign go    = ex && grp && !stop;

	// Inter-register operands and adder [RULE_19] [RULE_20] [RULE_21]
	logic [15:0] op1, op2, lres;
	logic [16:0] isum, add_a, add_q;
	logic        arith;
	assign op1   = ir_q[5] ? acc_q : 16'hffff;
	always_comb begin
		case (ir_q[4:3])
			2'b00:   op2 = 16'hffff;
			2'b01:   op2 = mask_q;
			2'b10:   op2 = aux_q;
			default: op2 = aux_q | mask_q;
		endcase
	end
	assign arith = (ir_q[7:6] == 2'b00);
	assign isum  = oc_add(op1, op2);
	always_comb begin
		case (ir_q[7:6])
			2'b01:   lres = op1 ^ op2;
			2'b10:   lres = op1 & op2;
			2'b11:   lres = ~(op1 & op2);
			default: lres = isum[15:0];
		endcase
	end
	assign add_a = oc_add(acc_q, dsx); // [RULE_06]
	assign add_q = oc_add(aux_q, dsx); // [RULE_10]

	// Completion and next address
	logic        fin, io_end, mem_end, run_req, tmo;
	logic [15:0] pc_n, pc1;
	assign pc1     = pc_q + 16'h0001;
	assign tmo     = (tmo_q == 16'(IO_WAIT_MAX - 1));
	assign io_end  = (state_q == S_IO) && (rep_s || rej_s || tmo);
	assign mem_end = (state_q == S_MEM) && mem_valid;
	assign run_req = psel && penable && pready_q && pwrite &&
		(paddr[7:0] == `RR_CTRL_OFS) && pwdata[`RR_CTRL_RUN];
	assign fin = (go && fc != `RR_FC_IN && fc != `RR_FC_OUT &&
		fc != `RR_FC_EXIT) || (ex && !grp) || io_end || mem_end ||
		((state_q == S_HALT) && run_req);
	always_comb begin
		pc_n = pc1; // Pass, nop and resumed halt [RULE_09]
		if (io_end && !rep_s) begin
			// Device reject or internal reject [RULE_05]
			pc_n = rej_s ? pc1 + dsx : pc_q + dsx;
		end else if (mem_end) begin
			pc_n = ctrl_q[`RR_CTRL_M32K] ?
				{1'b0, mem_rdata[14:0]} : mem_rdata; // [RULE_16]
		end
	end

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			ir_q    <= 16'h0000;
			pc_q    <= 16'h0000;
			irp_q   <= 1'b0;
			done_q  <= 1'b0;
			busy_q  <= 1'b0;
			halt_q  <= 1'b0;
			npc_q   <= 16'h0000;
			tmo_q   <= 16'h0000;
		end else if (clk_en) begin
			done_q <= fin;
			// Next-state flags, so both outputs leave a flop
			busy_q <= (state_q == S_IDLE) ? instr_valid : !fin;
			halt_q <= stop || ((state_q == S_HALT) && !run_req);
			if (fin) begin
				npc_q <= pc_n;
			end
			tmo_q <= (state_q == S_IO) ? tmo_q + 16'h0001 : 16'h0000;
			case (state_q)
				S_IDLE: if (instr_valid) begin
					ir_q    <= instr_word;
					pc_q    <= instr_pc;
					irp_q   <= instr_prot;
					state_q <= S_EXEC;
				end
				S_EXEC: begin
					if (stop) begin
						state_q <= S_HALT; // [RULE_02] [RULE_11]
					end else if (go && (fc == `RR_FC_IN ||
						fc == `RR_FC_OUT)) begin
						state_q <= S_IO;
					end else if (go && fc == `RR_FC_EXIT) begin
						state_q <= S_MEM;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_IO: if (io_end) begin
					state_q <= S_IDLE;
				end
				S_MEM: if (mem_end) begin
					state_q <= S_IDLE;
				end
				S_HALT: if (run_req) begin
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Working registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q  <= 16'h0000;
			aux_q  <= 16'h0000;
			mask_q <= 16'h0000;
		end else if (clk_en) begin
			if (io_end && rep_s && !io_q.dir_out) begin
				acc_q <= rdat_s; // [RULE_03]
			end
			if (go) begin
				case (fc)
					`RR_FC_BUMPA: acc_q <= add_a[15:0]; // [RULE_06]
					`RR_FC_LDA:   acc_q <= dsx; // [RULE_07]
					`RR_FC_LDQ:   aux_q <= dsx; // [RULE_08]
					`RR_FC_BUMPQ: aux_q <= add_q[15:0]; // [RULE_10]
					`RR_FC_IREG: begin
						// Every selected destination [RULE_22]
						if (ir_q[2]) acc_q <= lres;
						if (ir_q[1]) aux_q <= lres;
						if (ir_q[0]) mask_q <= lres;
					end
					default: ;
				endcase
			end
		end
	end

	// Overflow: sticky, set wins over the skip clear
	logic ovf_set, exi32;
	assign ovf_set = go && ((fc == `RR_FC_BUMPA && add_a[16]) ||
		(fc == `RR_FC_BUMPQ && add_q[16]) ||
		(fc == `RR_FC_IREG && arith && isum[16])); // [RULE_21]
	assign exi32 = mem_end && ctrl_q[`RR_CTRL_M32K];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else if (clk_en) begin
			if (exi32) begin
				ovf_q <= mem_rdata[15]; // [RULE_17]
			end else begin
				ovf_q <= ovf_set || (ovf_q && !ovf_clear); // [RULE_24]
			end
		end
	end

	// Interrupt system state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inta_q <= 1'b0;
			arm_q  <= 1'b0;
			pend_q <= 1'b0;
		end else if (clk_en) begin
			pend_q <= inta_q && |(irq_s & mask_q); // [RULE_13]
			if (fin && grp && state_q != S_HALT &&
				fc == `RR_FC_INT_ON) begin
				arm_q <= 1'b1; // Waits one instruction [RULE_12]
			end else if (fin && grp && state_q != S_HALT &&
				fc == `RR_FC_INT_OFF) begin
				inta_q <= 1'b0; // Arming dropped too [RULE_14]
				arm_q  <= 1'b0;
			end else if (mem_end) begin
				inta_q <= 1'b1; // [RULE_16]
				arm_q  <= 1'b0;
			end else if (fin && arm_q) begin
				inta_q <= 1'b1; // [RULE_12]
				arm_q  <= 1'b0;
			end
		end
	end

	// Device and storage requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_q     <= '0;
			strobe_q <= 1'b0;
			memrd_q  <= 1'b0;
			protwr_q <= 1'b0;
			protv_q  <= 1'b0;
			maddr_q  <= 16'h0000;
		end else if (clk_en) begin
			protwr_q <= 1'b0;
			if (go && (fc == `RR_FC_IN || fc == `RR_FC_OUT)) begin
				// Aux picks the device [RULE_03] [RULE_04]
				io_q.dir_out <= (fc == `RR_FC_OUT);
				io_q.addr    <= aux_q;
				io_q.wdata   <= acc_q;
				strobe_q     <= 1'b1;
			end else if (io_end) begin
				strobe_q <= 1'b0;
			end
			if (go && (fc == `RR_FC_PSET || fc == `RR_FC_PCLR)) begin
				protwr_q <= 1'b1; // [RULE_15]
				protv_q  <= (fc == `RR_FC_PSET);
				maddr_q  <= aux_q;
			end
			if (go && fc == `RR_FC_EXIT) begin
				memrd_q <= 1'b1; // Return word slot [RULE_16]
				maddr_q <= dsx;
			end else if (mem_end) begin
				memrd_q <= 1'b0;
			end
		end
	end

	// Protect fault: sticky status and one-cycle pulse
	logic fault_set, fault_clr;
	assign fault_set = ex && grp && ((priv && !legal) || mviol); // [RULE_18]
	assign fault_clr = psel && penable && pready_q && pwrite &&
		(paddr[7:0] == `RR_STAT_OFS) && pwdata[`RR_ST_FAULT];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q  <= 1'b0;
			fpulse_q <= 1'b0;
		end else if (clk_en) begin
			fpulse_q <= fault_set; // [RULE_11]
			fault_q  <= fault_set || (fault_q && !fault_clr);
		end
	end

	// APB slave: one wait state, answer registered
	logic [31:0] rd_mux;
	logic        hit;
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr[7:0])
			`RR_CTRL_OFS: rd_mux = {29'h0, ctrl_q};
			`RR_STAT_OFS: rd_mux = {26'h0, state_q != S_IDLE, pend_q,
				fault_q, inta_q, ovf_q, state_q == S_HALT};
			`RR_ACC_OFS:  rd_mux = {16'h0000, acc_q};
			`RR_AUX_OFS:  rd_mux = {16'h0000, aux_q};
			`RR_MASK_OFS: rd_mux = {16'h0000, mask_q};
			default:      hit = 1'b0;
		endcase
		if (paddr[31:8] != 24'h000000) begin
			hit = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			ctrl_q    <= `RR_CTRL_RST;
		end else if (clk_en) begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !hit;
			if (psel && penable && !pready_q) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			end
			if (psel && penable && pready_q && pwrite && hit &&
				paddr[7:0] == `RR_CTRL_OFS) begin
				ctrl_q <= pwdata[2:0];
			end
		end
	end

	// Outputs, each straight from a flop
	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign busy        = busy_q;
	assign done        = done_q;
	assign next_pc     = npc_q;
	assign io_out      = io_q;
	assign io_strobe   = strobe_q;
	assign mem_rd      = memrd_q;
	assign prot_wr     = protwr_q;
	assign prot_val    = protv_q;
	assign mem_addr    = maddr_q;
	assign int_active  = inta_q;
	assign int_pending = pend_q;
	assign fault_pulse = fpulse_q;
	assign halted      = halt_q;
	assign overflow    = ovf_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !clk_en);

	chk_group_decode: assert property (ex && !grp |=> done_q && // [RULE_01]
		npc_q == $past(pc1)) else $error("non-group word not passed");
	chk_halt_switch: assert property (ex && grp && fc == 4'h0 && // [RULE_02]
		ctrl_q[`RR_CTRL_HALT] |=> halted)
		else $error("selective halt not taken");
	chk_io_start: assert property (go && fc == `RR_FC_IN |=> // [RULE_03]
		strobe_q && !io_q.dir_out && io_q.addr == $past(aux_q))
		else $error("input transfer not started");
	chk_reject_pc: assert property (io_end && rej_s && !rep_s |=> // [RULE_05]
		done_q && npc_q == $past(pc_q) + 16'h0001 + $past(dsx))
		else $error("reject address wrong");
	chk_enter_acc: assert property (go && fc == `RR_FC_LDA |=> // [RULE_07]
		acc_q == $past(dsx)) else $error("enter acc wrong");
	chk_enter_aux: assert property (go && fc == `RR_FC_LDQ |=> // [RULE_08]
		aux_q == $past(dsx)) else $error("enter aux wrong");
	chk_priv_halt: assert property (ex && grp && priv && !legal |=> // [RULE_11]
		halted && fpulse_q ##1 !fpulse_q) else $error("illegal op ran");
	chk_ovf_sticky: assert property (ovf_q && !ovf_clear && !exi32 // [RULE_24]
		|=> ovf_q) else $error("overflow lost");
	chk_int_mask: assert property (!inta_q |=> !pend_q) // [RULE_13]
		else $error("interrupt seen while inactive");
	chk_inhibit: assert property (go && fc == `RR_FC_INT_OFF |=> // [RULE_14]
		!inta_q && !arm_q) else $error("inhibit failed");

endmodule // register_reference_exec
`default_nettype wire

// file: test/io_dev_model.sv
// Behavioural model of the addressed I/O device answering a transfer.
`timescale 1ns/10ps
`default_nettype none

module io_dev_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Request from the execute unit
	input  wire logic        io_strobe,
	input  wire logic [15:0] dev_sel,
	// Answer kind (0 reply, 1 reject, 2 silent) and its delay
	input  wire logic [1:0]  mode,
	input  wire logic [2:0]  delay,
	// Answer pins
	output logic             io_reply,
	output logic             io_reject,
	output logic      [15:0] io_rdata
);
	logic [2:0] cnt_q;

	// Answer held as a level until the strobe drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= 3'h0;
			io_reply  <= 1'b0;
			io_reject <= 1'b0;
			io_rdata  <= 16'h0;
		end else if (!io_strobe) begin
			cnt_q     <= 3'h0;
			io_reply  <= 1'b0;
			io_reject <= 1'b0;
			io_rdata  <= ~io_rdata; // Released bus never holds a value
		end else if (cnt_q != delay) begin
			cnt_q <= cnt_q + 3'h1;
		end else if (mode != 2'h2) begin
			io_reply  <= (mode == 2'h0);
			io_reject <= (mode == 2'h1);
			io_rdata  <= {dev_sel[7:0], 8'h3c};
		end
	end
endmodule // io_dev_model
`default_nettype wire

// file: test/register_reference_exec_test.sv
// Self-checking bench for the register-reference execute unit.
`timescale 1ns/10ps
`default_nettype none
`include "rr_exec_regs.svh"

module register_reference_exec_test
	import rr_exec_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        instr_valid, instr_prot, ovf_clear, busy, done, io_strobe;
	logic        io_reply, io_reject, mem_rd, prot_wr, prot_val, mem_valid;
	logic        int_active, int_pending, fault_pulse, halted, overflow, pw_v;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [15:0] instr_word, instr_pc, next_pc, io_rdata, mem_addr;
	logic [15:0] mem_rdata, irq_req, pc, ret_w, rd_addr, pw_a;
	logic [1:0]  mode;
	logic [2:0]  delay;
	io_req_t     io_out, io_seen;
	int          failures, num_checks, cyc, dn, faults, pws;

	register_reference_exec #(.IO_WAIT_MAX(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_prot(instr_prot),
		.instr_pc(instr_pc), .ovf_clear(ovf_clear), .busy(busy),
		.done(done), .next_pc(next_pc), .io_out(io_out),
		.io_strobe(io_strobe), .io_reply(io_reply),
		.io_reject(io_reject), .io_rdata(io_rdata), .mem_rd(mem_rd),
		.prot_wr(prot_wr), .prot_val(prot_val), .mem_addr(mem_addr),
		.mem_valid(mem_valid), .mem_rdata(mem_rdata), .irq_req(irq_req),
		.int_active(int_active), .int_pending(int_pending),
		.fault_pulse(fault_pulse), .halted(halted), .overflow(overflow)
	);

	io_dev_model io_u (
		.pclk(pclk), .presetn(presetn), .io_strobe(io_strobe),
		.dev_sel(io_out.addr), .mode(mode), .delay(delay),
		.io_reply(io_reply), .io_reject(io_reject), .io_rdata(io_rdata)
	);

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	// Pulse counters, captures, storage answer and hang limit
	always @(posedge pclk) begin
		cyc++;
		if (done === 1'b1) dn++;
		if (fault_pulse === 1'b1) faults++;
		if (prot_wr === 1'b1) begin
			pws++;
			pw_a = mem_addr;
			pw_v = prot_val;
		end
		if (io_strobe === 1'b1) io_seen = io_out;
		if (mem_rd === 1'b1) rd_addr = mem_addr;
		mem_valid <= (mem_rd === 1'b1) && !mem_valid;
		mem_rdata <= ret_w;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q  = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic st(input int b, input logic e);
		apb(1'b0, `RR_STAT_OFS, 32'h0);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask

	// Issue one word; returns after completion or on halt
	task automatic ex(input logic [15:0] w, input logic p);
		int d0;
		d0 = dn;
		pc = pc + 16'h0010;
		@(posedge pclk);
		instr_valid <= 1'b1;
		instr_word  <= w;
		instr_prot  <= p;
		instr_pc    <= pc;
		@(posedge pclk);
		instr_valid <= 1'b0;
		do begin
			@(negedge pclk);
		end while (dn == d0 && halted !== 1'b1);
	endtask

	task automatic resume(input logic [31:0] c);
		int d0;
		d0 = dn;
		apb(1'b1, `RR_CTRL_OFS, c | 32'h8);
		while (dn == d0) begin
			@(negedge pclk);
		end
	endtask

	task automatic ovfc();
		@(posedge pclk);
		ovf_clear <= 1'b1;
		@(posedge pclk);
		ovf_clear <= 1'b0;
	endtask

	task automatic t_simple();
		ex(16'h0a05, 1'b0);
		chk(next_pc, pc + 16'h1);
		rdr(`RR_ACC_OFS, 32'h5);
		ex(16'h0aff, 1'b0);
		rdr(`RR_ACC_OFS, 32'hffff);
		ex(16'h0c80, 1'b0);
		rdr(`RR_AUX_OFS, 32'hff80);
		ex(16'h1234, 1'b0);
		chk(next_pc, pc + 16'h1);
		rdr(`RR_ACC_OFS, 32'hffff);
		ex(16'h0b00, 1'b0);
		rdr(`RR_AUX_OFS, 32'hff80);
		ex(16'h0d05, 1'b0);
		rdr(`RR_AUX_OFS, 32'hff85);
		ex(16'h0902, 1'b0);
		rdr(`RR_ACC_OFS, 32'h2);
		rdr(8'h14, 32'h0);
		chk({31'h0, er}, 32'h1);
	endtask

	// Doubling through aux until the sum leaves the positive range
	task automatic t_ovf();
		ovfc();
		ex(16'h0a40, 1'b0);
		repeat (8) begin
			ex(16'h0822, 1'b0);
			ex(16'h0834, 1'b0);
		end
		rdr(`RR_ACC_OFS, 32'h4000);
		st(1, 1'b0);
		ex(16'h0822, 1'b0);
		ex(16'h0834, 1'b0);
		rdr(`RR_ACC_OFS, 32'h8000);
		st(1, 1'b1);
		ex(16'h0b00, 1'b0);
		st(1, 1'b1);
		ovfc();
		st(1, 1'b0);
	endtask

	task automatic t_ireg();
		logic [15:0] e[4] = '{16'h0080, 16'h007e, 16'h0001, 16'hfffe};
		ex(16'h0a71, 1'b0);
		ex(16'h0c0f, 1'b0);
		for (int k = 0; k < 4; k++) begin
			ex({8'h08, k[1:0], 6'h31}, 1'b1);
			rdr(`RR_MASK_OFS, {16'h0, e[k]});
		end
		ex(16'h080e, 1'b0);
		rdr(`RR_ACC_OFS, 32'hfffe);
		rdr(`RR_AUX_OFS, 32'hfffe);
	endtask

	task automatic t_halt();
		apb(1'b1, `RR_CTRL_OFS, 32'h1);
		ex(16'h0000, 1'b0);
		chk({31'h0, halted}, 32'h1);
		resume(32'h1);
		chk({31'h0, halted}, 32'h0);
		chk(next_pc, pc + 16'h1);
		apb(1'b1, `RR_CTRL_OFS, 32'h0);
		ex(16'h0000, 1'b0);
		chk({31'h0, halted}, 32'h0);
		chk(next_pc, pc + 16'h1);
	endtask

	task automatic t_prot();
		int f0;
		apb(1'b1, `RR_CTRL_OFS, 32'h2);
		ex(16'h0400, 1'b0);
		chk({31'h0, halted}, 32'h1);
		resume(32'h2);
		// Clear the sticky fault so the next one is its own
		apb(1'b1, `RR_STAT_OFS, 32'h8);
		st(3, 1'b0);
		f0 = faults;
		ex(16'h0801, 1'b0);
		chk({31'h0, halted}, 32'h1);
		st(3, 1'b1);
		chk(faults - f0, 32'h1);
		rdr(`RR_MASK_OFS, 32'hfffe);
		resume(32'h2);
		ex(16'h0500, 1'b1);
		chk({31'h0, halted}, 32'h0);
		apb(1'b1, `RR_CTRL_OFS, 32'h0);
	endtask

	task automatic t_pbit();
		int p0;
		p0 = pws;
		ex(16'h0600, 1'b0);
		chk(pws - p0, 32'h1);
		chk({pw_v, pw_a}, {1'b1, 16'hfffe});
		ex(16'h0700, 1'b1);
		chk({pw_v, pw_a}, {1'b0, 16'hfffe});
	endtask

	task automatic t_int();
		@(posedge pclk);
		irq_req <= 16'h0001;
		ex(16'h0400, 1'b1);
		chk({31'h0, int_active}, 32'h0);
		ex(16'h0b00, 1'b0);
		chk({30'h0, int_active, int_pending}, 32'h2);
		@(posedge pclk);
		irq_req <= 16'h0002;
		repeat (5) @(negedge pclk);
		chk({31'h0, int_pending}, 32'h1);
		ex(16'h0500, 1'b1);
		chk({30'h0, int_active, int_pending}, 32'h0);
		ovfc();
		apb(1'b1, `RR_CTRL_OFS, 32'h4);
		ret_w = 16'h8123;
		ex(16'h0e05, 1'b1);
		chk({rd_addr, next_pc}, {16'h0005, 16'h0123});
		chk({30'h0, overflow, int_active}, 32'h3);
		ovfc();
		apb(1'b1, `RR_CTRL_OFS, 32'h0);
		ret_w = 16'h8456;
		ex(16'h0e02, 1'b1);
		chk({rd_addr, next_pc}, {16'h0002, 16'h8456});
		chk({31'h0, overflow}, 32'h0);
	endtask

	task automatic t_io();
		ex(16'h0c21, 1'b0);
		ex(16'h0a42, 1'b0);
		ex(16'h0203, 1'b0);
		chk(next_pc, pc + 16'h1);
		chk({io_seen.dir_out, io_seen.addr}, {1'b0, 16'h0021});
		rdr(`RR_ACC_OFS, 32'h213c);
		@(posedge pclk);
		mode  <= 2'h1;
		delay <= 3'h3;
		ex(16'h0303, 1'b0);
		chk(next_pc, pc + 16'h4);
		chk({io_seen.dir_out, io_seen.wdata}, {1'b1, 16'h213c});
		@(posedge pclk);
		mode <= 2'h2;
		ex(16'h0304, 1'b0);
		chk(next_pc, pc + 16'h4);
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Reset, then the scenarios in turn
	initial begin
		pclk    = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, instr_valid, instr_prot} = '0;
		{ovf_clear, paddr, pwdata, mode, delay} = '0;
		{instr_word, instr_pc, irq_req, pc, ret_w} = '0;
		repeat (3) @(posedge pclk);
		chk({halted, overflow, int_active, busy, pready, next_pc}, 32'h0);
		presetn <= 1'b1;
		t_simple();
		t_ovf();
		t_ireg();
		t_halt();
		t_prot();
		t_pbit();
		t_int();
		t_io();
		report_and_stop();
	end
endmodule // register_reference_exec_test
`default_nettype wire
